// *** src/lcd_cfg_pkg.sv ***
// Constants and types for the LCD pin, duty and power configuration block.
// Assumes one 250 MHz clock and word-aligned AHB-Lite register access.
// What this block does
// R01 - Pin and duty register resets to zero
// R02 - Duty bits pick static, 1/2, 1/3, 1/4
// R03 - Static paralleled: commons two to four copy one
// R04 - Half paralleled: four copies three, two copies one
// R05 - Software leaves unused commons unconnected
// R06 - Expansion bit turns pins 40-37 into expansion
// R07 - Expansion off, field zero: all pins ports
// R08 - Field enables segment groups of eight from top
// R09 - Expansion on needs field zero; rest are ports
// R10 - Control register resets to 0x80
// R11 - Control bit 7 reads one, ignores writes
// R12 - Bit 6 switches the drive supply
// R13 - Supply off when inactive or in standby
// R14 - Activate, display and frame select are read/write
// R15 - Clearing activate halts controller, keeps registers
// R16 - Display bit zero shows blank data
package lcd_cfg_pkg;
	// Register byte addresses
	localparam logic [11:0] ADDR_PIN_DUTY = 12'h000;
	localparam logic [11:0] ADDR_POWER = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	// Reset values
	localparam logic [7:0] PIN_DUTY_RESET = 8'h00;
	localparam logic [7:0] POWER_RESET = 8'h80;
	// Pin and duty register fields
	localparam int DUTY_LSB = 6;
	localparam int PAR_BIT = 5;
	localparam int EXP_BIT = 4;
	localparam int GRP_LSB = 0;
	// Power and display register fields
	localparam int RSVD_BIT = 7;
	localparam int SUPPLY_SW_BIT = 6;
	localparam int ACTIVATE_BIT = 5;
	localparam int SHOW_MEM_BIT = 4;
	localparam int FRAME_SEL_LSB = 0;
	// Status register fields
	localparam int ST_SUPPLY = 0;
	localparam int ST_BADCFG = 1;
	localparam int ST_RUN = 2;
	// Geometry
	localparam int SEG_GROUPS = 5;
	localparam int SEG_PINS = 40;
	typedef enum logic [1:0] {
		DUTY_STATIC = 2'b00,
		DUTY_HALF = 2'b01,
		DUTY_THIRD = 2'b10,
		DUTY_QUARTER = 2'b11
	} duty_t;
endpackage

// *** src/lcd_pin_decode.sv ***
// Decodes duty, paralleling and segment group fields into pin use.
// Assumes the caller registers the results before they reach pins.
`timescale 1ns/1ps
module lcd_pin_decode (
	lcd_pin_if.dec pin // Fields in, pin use out
);
	logic [2:0] groups;

	// Common routing; com_src gives a 2-bit phase per common, first lowest
	always_comb begin
		pin.com_count = {1'b0, pin.duty} + 3'd1; // R02
		case (pin.duty)
			lcd_cfg_pkg::DUTY_STATIC: begin
				pin.com_en = pin.parallel ? 4'hf : 4'h1;
				pin.com_src = 8'h00; // R03
			end
			lcd_cfg_pkg::DUTY_HALF: begin
				pin.com_en = pin.parallel ? 4'hf : 4'h3;
				pin.com_src = pin.parallel ? 8'h50 : 8'h04; // R04
			end
			lcd_cfg_pkg::DUTY_THIRD: begin
				// Paralleling has no effect, common four stays idle
				pin.com_en = 4'h7; // R05
				pin.com_src = 8'h24;
			end
			default: begin
				pin.com_en = 4'hf;
				pin.com_src = 8'he4;
			end
		endcase
	end

	// Number of top groups in segment use
	always_comb begin
		pin.bad_cfg = pin.expansion && (pin.group_sel != 4'h0); // R09
		if (pin.expansion) begin
			groups = 3'd0; // R09
		end else if (pin.group_sel[3]) begin
			groups = 3'd5; // R08
		end else if (pin.group_sel[2:1] != 2'b00) begin
			groups = {1'b0, pin.group_sel[2:1]} + 3'd1; // R08
		end else begin
			groups = {2'b00, pin.group_sel[0]}; // R07
		end
	end

	// Group g covers pins 8g+1 to 8g+8; enabled from the top down
	for (genvar g = 0; g < lcd_cfg_pkg::SEG_GROUPS; g++) begin : g_seg
		assign pin.seg_en[g*8 +: 8] =
			{8{(4'(g) + {1'b0, groups}) >= 4'd5}}; // R08
	end
endmodule

// *** src/lcd_pin_if.sv ***
// Carries configuration fields to the pin decoder and decoded pin use back.
// Assumes the decoder is purely combinational.
`timescale 1ns/1ps
interface lcd_pin_if;
	lcd_cfg_pkg::duty_t duty;
	logic parallel;
	logic expansion;
	logic [3:0] group_sel;
	logic [3:0] com_en;
	logic [7:0] com_src;
	logic [2:0] com_count;
	logic [39:0] seg_en;
	logic bad_cfg;
	modport cfg (output duty, parallel, expansion, group_sel,
		input com_en, com_src, com_count, seg_en, bad_cfg);
	modport dec (input duty, parallel, expansion, group_sel,
		output com_en, com_src, com_count, seg_en, bad_cfg);
endinterface

// *** src/lcd_port_duty_power_control.sv ***
// Register bank for LCD pin use, duty cycle and drive supply control.
// Assumes a single AHB-Lite master and synchronous standby input.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module lcd_port_duty_power_control (
	input wire logic sys_clk_i, // 250 MHz clock
	input wire logic rst_n_i, // Async reset, active low
	input wire logic hsel_i, // Slave select
	input wire logic [31:0] haddr_i, // Byte address
	input wire logic [1:0] htrans_i, // Transfer type
	input wire logic hwrite_i, // Write when high
	input wire logic [2:0] hsize_i, // Transfer size
	input wire logic hready_i, // Bus ready
	input wire logic [31:0] hwdata_i, // Write data
	output logic [31:0] hrdata_o, // Read data
	output logic hreadyout_o, // Slave ready
	output logic hresp_o, // Always OKAY
	input wire logic standby_i, // Chip in standby
	output logic [3:0] com_en_o, // Common outputs driven
	output logic [7:0] com_src_o, // Phase per common
	output logic [2:0] com_count_o, // Commons in duty
	output logic [39:0] seg_drive_en_o, // Segment pin is driver
	output logic expansion_en_o, // Pins 40-37 expansion
	output logic drive_supply_on_o, // LCD drive supply
	output logic controller_run_o, // Controller operates
	output logic show_memory_o, // Show display memory
	output logic [3:0] frame_clock_sel_o, // Frame clock select
	output logic bad_config_o // Prohibited field use
);
	logic rst_meta_reg;
	logic rst_sync_n;
	logic wr_pend_reg, wr_pend_next;
	logic [11:0] waddr_reg, waddr_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] pin_reg, pin_next;
	logic [6:0] ctrl_reg, ctrl_next;
	logic accept;
	logic [11:0] aaddr;
	logic supply_next;
	lcd_pin_if pin ();

	// Reset release through two flops; assert stays asynchronous
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n <= rst_meta_reg;
		end
	end

	// Address phase capture; data phase of a write lands next cycle
	assign accept = hsel_i && htrans_i[1] && hready_i;
	assign aaddr = {haddr_i[11:2], 2'b00};

	// Register next values from a pending write
	always_comb begin
		pin_next = pin_reg;
		ctrl_next = ctrl_reg;
		if (wr_pend_reg) begin
			case (waddr_reg)
				lcd_cfg_pkg::ADDR_PIN_DUTY: begin
					pin_next = hwdata_i[7:0];
				end
				lcd_cfg_pkg::ADDR_POWER: begin
					// Top bit is not stored, writes to it vanish
					ctrl_next = hwdata_i[6:0]; // R11 R14
				end
				default: begin
				end
			endcase
		end
	end

	// Bus state; read data is taken from next values so that a read
	// right behind a write sees the fresh contents
	always_comb begin
		wr_pend_next = accept && hwrite_i;
		waddr_next = accept ? aaddr : waddr_reg;
		rdata_next = rdata_reg;
		if (accept && !hwrite_i) begin
			case (aaddr)
				lcd_cfg_pkg::ADDR_PIN_DUTY: begin
					rdata_next = {24'h000000, pin_next};
				end
				lcd_cfg_pkg::ADDR_POWER: begin
					rdata_next = {24'h000000, 1'b1, ctrl_next}; // R11
				end
				lcd_cfg_pkg::ADDR_STATUS: begin
					rdata_next = 32'h00000000;
					rdata_next[lcd_cfg_pkg::ST_SUPPLY] = drive_supply_on_o;
					rdata_next[lcd_cfg_pkg::ST_BADCFG] = bad_config_o;
					rdata_next[lcd_cfg_pkg::ST_RUN] = controller_run_o;
				end
				default: begin
					// Unmapped reads answer zero
					rdata_next = 32'h00000000;
				end
			endcase
		end
	end

	// Bus and register flops; zero wait states, always OKAY
	always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			wr_pend_reg <= 1'b0;
			waddr_reg <= 12'h000;
			rdata_reg <= 32'h00000000;
			pin_reg <= lcd_cfg_pkg::PIN_DUTY_RESET; // R01
			ctrl_reg <= lcd_cfg_pkg::POWER_RESET[6:0]; // R10
		end else begin
			wr_pend_reg <= wr_pend_next;
			waddr_reg <= waddr_next;
			rdata_reg <= rdata_next;
			pin_reg <= pin_next;
			ctrl_reg <= ctrl_next;
		end
	end

	assign hrdata_o = rdata_reg;
	assign hreadyout_o = rst_sync_n;
	assign hresp_o = 1'b0;

	// Feed the decoder from the stored fields
	assign pin.duty = lcd_cfg_pkg::duty_t'(
		pin_reg[lcd_cfg_pkg::DUTY_LSB +: 2]); // R02
	assign pin.parallel = pin_reg[lcd_cfg_pkg::PAR_BIT];
	assign pin.expansion = pin_reg[lcd_cfg_pkg::EXP_BIT]; // R06
	assign pin.group_sel = pin_reg[lcd_cfg_pkg::GRP_LSB +: 4];

	lcd_pin_decode u_decode (
		.pin (pin.dec)
	);

	// Supply needs switch, activate and no standby
	always_comb begin
		supply_next = ctrl_reg[lcd_cfg_pkg::SUPPLY_SW_BIT] // R12
			&& ctrl_reg[lcd_cfg_pkg::ACTIVATE_BIT] // R13
			&& !standby_i; // R13
	end

	// Output flops; halt keeps registers, only the run and supply outputs drop
	always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			com_en_o <= 4'h0;
			com_src_o <= 8'h00;
			com_count_o <= 3'h0;
			seg_drive_en_o <= 40'h0000000000;
			expansion_en_o <= 1'b0;
			drive_supply_on_o <= 1'b0;
			controller_run_o <= 1'b0;
			show_memory_o <= 1'b0;
			frame_clock_sel_o <= 4'h0;
			bad_config_o <= 1'b0;
		end else begin
			com_en_o <= pin.com_en; // R03 R04
			com_src_o <= pin.com_src; // R03 R04
			com_count_o <= pin.com_count; // R02
			seg_drive_en_o <= pin.seg_en; // R07 R08
			expansion_en_o <= pin.expansion; // R06
			drive_supply_on_o <= supply_next; // R12 R13
			controller_run_o <= ctrl_reg[lcd_cfg_pkg::ACTIVATE_BIT]; // R15
			show_memory_o <= ctrl_reg[lcd_cfg_pkg::SHOW_MEM_BIT]; // R16
			frame_clock_sel_o <= ctrl_reg[lcd_cfg_pkg::FRAME_SEL_LSB +: 4]; // R14
			bad_config_o <= pin.bad_cfg; // R09
		end
	end

	// Checks on the pin decode, supply gating and register access
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_sync_n);

	sequence s_ctrl_read;
		accept && !hwrite_i && (aaddr == lcd_cfg_pkg::ADDR_POWER);
	endsequence

	sequence s_ctrl_write;
		accept && hwrite_i && (aaddr == lcd_cfg_pkg::ADDR_POWER)
			##1 1'b1;
	endsequence

	a_pin_reset: assert property ( // R01
		$rose(rst_sync_n) |-> pin_reg == 8'h00 && com_en_o == 4'h0
	) else $error("pin register not zero after reset");

	a_ctrl_reset: assert property ( // R10
		$rose(rst_sync_n) |-> ctrl_reg == 7'h00
	) else $error("control register not cleared after reset");

	a_duty_count: assert property ( // R02
		1'b1 |=> com_count_o == 3'($past(pin_reg[7:6])) + 3'd1
	) else $error("common count does not follow duty");

	a_static_par: assert property ( // R03
		pin_reg[7:5] == 3'b001 |=> com_en_o == 4'hf
			&& com_src_o == 8'h00
	) else $error("static paralleled commons differ");

	a_half_par: assert property ( // R04
		pin_reg[7:5] == 3'b011 |=> com_en_o == 4'hf
			&& com_src_o == 8'h50
	) else $error("half duty paralleled commons wrong");

	a_exp_pins: assert property ( // R06
		pin_reg[4] |=> expansion_en_o && seg_drive_en_o[39:36] == 4'h0
	) else $error("expansion pins still segment drivers");

	a_all_ports: assert property ( // R07
		pin_reg[4:0] == 5'h00 |=> seg_drive_en_o == 40'h0000000000
			&& !expansion_en_o
	) else $error("segment pins not released to ports");

	a_seg_two: assert property ( // R08
		pin_reg[4:1] == 4'b0001 |=> seg_drive_en_o == 40'hffff000000
	) else $error("two top groups not selected");

	a_seg_all: assert property ( // R08
		pin_reg[4:3] == 2'b01 |=> seg_drive_en_o == 40'hffffffffff
	) else $error("all groups not selected");

	a_exp_guard: assert property ( // R09
		pin_reg[4] |=> seg_drive_en_o == 40'h0000000000
			&& bad_config_o == ($past(pin_reg[3:0]) != 4'h0)
	) else $error("expansion mode pin use wrong");

	a_bit7_one: assert property ( // R11
		s_ctrl_read |=> hrdata_o[7] && hrdata_o[31:8] == 24'h000000
	) else $error("control bit 7 not read as one");

	a_supply_on: assert property ( // R12
		ctrl_reg[6:5] == 2'b11 && !standby_i |=> drive_supply_on_o
	) else $error("drive supply not on");

	a_supply_gate: assert property ( // R13
		!ctrl_reg[5] || standby_i || !ctrl_reg[6]
			|=> !drive_supply_on_o
	) else $error("drive supply on while gated");

	a_ctrl_rw: assert property ( // R14
		s_ctrl_write |=> ctrl_reg == $past(hwdata_i[6:0], 1)
	) else $error("control fields not written");

	a_run_halt: assert property ( // R15
		!ctrl_reg[5] ##1 !ctrl_reg[5] |-> !controller_run_o
			&& ($stable(pin_reg) || $past(wr_pend_reg))
	) else $error("controller runs while inactive");

	a_blank: assert property ( // R16
		1'b1 |=> show_memory_o == $past(ctrl_reg[4])
	) else $error("display select not followed");

	// Further decode checks, one per duty and segment field code
	a_static_plain: assert property ( // R02
		pin_reg[7:5] == 3'b000 |=> com_en_o == 4'h1
			&& com_src_o == 8'h00
	) else $error("static commons wrong");

	a_half_plain: assert property ( // R02
		pin_reg[7:5] == 3'b010 |=> com_en_o == 4'h3
			&& com_src_o == 8'h04
	) else $error("half duty commons wrong");

	// Paralleling must not wake common four at third duty
	a_third_idle: assert property ( // R02
		pin_reg[7:6] == 2'b10 |=> com_en_o == 4'h7
			&& com_count_o == 3'd3
	) else $error("third duty commons wrong");

	a_quarter: assert property ( // R02
		pin_reg[7:6] == 2'b11 |=> com_en_o == 4'hf
			&& com_src_o == 8'he4
	) else $error("quarter duty commons wrong");

	a_seg_one: assert property ( // R08
		pin_reg[4:0] == 5'h01 |=> seg_drive_en_o == 40'hff00000000
	) else $error("top group not selected");

	a_seg_three: assert property ( // R08
		pin_reg[4:1] == 4'b0010 |=> seg_drive_en_o == 40'hffffff0000
	) else $error("three top groups not selected");

	a_seg_four: assert property ( // R08
		pin_reg[4:1] == 4'b0011 |=> seg_drive_en_o == 40'hffffffff00
	) else $error("four top groups not selected");

	a_exp_off: assert property ( // R06
		!pin_reg[4] |=> !expansion_en_o && !bad_config_o
	) else $error("expansion pins taken while off");

	a_bad_follow: assert property ( // R09
		1'b1 |=> bad_config_o == ($past(pin_reg[4])
			&& $past(pin_reg[3:0]) != 4'h0)
	) else $error("prohibited field flag wrong");

	// Register file paths, checked against the stored or pending values
	sequence s_pin_write;
		accept && hwrite_i && (aaddr == lcd_cfg_pkg::ADDR_PIN_DUTY)
			##1 1'b1;
	endsequence

	sequence s_pin_read;
		accept && !hwrite_i && (aaddr == lcd_cfg_pkg::ADDR_PIN_DUTY)
			&& !wr_pend_reg;
	endsequence

	sequence s_status_read;
		accept && !hwrite_i && (aaddr == lcd_cfg_pkg::ADDR_STATUS);
	endsequence

	a_pin_write: assert property ( // R02
		s_pin_write |=> pin_reg == $past(hwdata_i[7:0], 1)
	) else $error("pin register not written");

	a_pin_read: assert property ( // R02
		s_pin_read |=> hrdata_o == {24'h000000, $past(pin_reg)}
	) else $error("pin register read wrong");

	// Pending write bypass included, as in the read mux
	a_ctrl_fields: assert property ( // R14
		s_ctrl_read |=> hrdata_o[6:0] == $past(ctrl_next)
	) else $error("control fields read wrong");

	a_status_bits: assert property ( // R09
		s_status_read |=>
			hrdata_o[lcd_cfg_pkg::ST_BADCFG] == $past(bad_config_o)
			&& hrdata_o[lcd_cfg_pkg::ST_SUPPLY] == $past(drive_supply_on_o)
			&& hrdata_o[lcd_cfg_pkg::ST_RUN] == $past(controller_run_o)
	) else $error("status bits read wrong");

	// Supply, run and frame select outputs track their control bits and standby
	sequence s_standby_enter;
		!standby_i ##1 standby_i;
	endsequence

	a_stby_drop: assert property ( // R13
		s_standby_enter |=> !drive_supply_on_o
	) else $error("supply stays on into standby");

	a_halt_supply: assert property ( // R15
		!ctrl_reg[5] |=> !drive_supply_on_o && !controller_run_o
	) else $error("halt leaves supply or run on");

	a_run_follow: assert property ( // R15
		1'b1 |=> controller_run_o == $past(ctrl_reg[5])
	) else $error("run output does not follow activate");

	a_frame_sel: assert property ( // R14
		1'b1 |=> frame_clock_sel_o == $past(ctrl_reg[3:0])
	) else $error("frame select not followed");
endmodule

// *** testbench/lcd_panel_model.sv ***
// Panel and segment expander seen from the pin-use outputs.
// Assumes the decoded pin use is stable between register writes.
`timescale 1ns/1ps
module lcd_panel_model (
	input wire logic [3:0] com_en_i, // Commons driven
	input wire logic [39:0] seg_en_i, // Segment drivers
	input wire logic expansion_i, // Pins 40-37 go to expander
	output logic [2:0] commons_wired_o, // Commons tied to glass
	output logic [5:0] segments_lit_o // Segment lines on glass
);
	// Undriven commons are left open on the glass
	always_comb begin
		commons_wired_o = 3'($countones(com_en_i));
		segments_lit_o = 6'($countones(seg_en_i & (expansion_i ?
			40'h0f_ffff_ffff : {40{1'b1}})));
	end
endmodule

// *** testbench/lcd_port_duty_power_control_test.sv ***
// Bench for the LCD pin, duty and power register bank over AHB-Lite.
// Assumes a zero-wait slave; every wait is still bounded by a timeout.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h expected %h", $time, a, e); end end
module lcd_port_duty_power_control_test;
	logic sys_clk_i = 0, rst_n_i = 0, hsel_i = 0, hwrite_i = 0;
	logic standby_i = 0;
	logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
	logic [1:0] htrans_i = 0;
	logic hreadyout_o, hresp_o, expansion_en_o, drive_supply_on_o;
	logic controller_run_o, show_memory_o, bad_config_o;
	logic [3:0] com_en_o, frame_clock_sel_o;
	logic [7:0] com_src_o;
	logic [2:0] com_count_o, wired;
	logic [39:0] seg_drive_en_o, exp_seg;
	logic [5:0] lit;
	logic [3:0] en_tab [8] = '{4'h1, 4'hf, 4'h3, 4'hf, 4'h7, 4'h7, 4'hf, 4'hf};
	logic [7:0] src_tab [8] = '{8'h00, 8'h00, 8'h04, 8'h50, 8'h24, 8'h24,
		8'he4, 8'he4};
	int miscompares = 0, compares = 0, cycles = 0, g;
	localparam logic [11:0] P = lcd_cfg_pkg::ADDR_PIN_DUTY;
	localparam logic [11:0] C = lcd_cfg_pkg::ADDR_POWER;
	localparam logic [11:0] S = lcd_cfg_pkg::ADDR_STATUS;

	lcd_port_duty_power_control DUT (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'b010),
		.hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .standby_i(standby_i),
		.com_en_o(com_en_o), .com_src_o(com_src_o),
		.com_count_o(com_count_o), .seg_drive_en_o(seg_drive_en_o),
		.expansion_en_o(expansion_en_o),
		.drive_supply_on_o(drive_supply_on_o),
		.controller_run_o(controller_run_o), .show_memory_o(show_memory_o),
		.frame_clock_sel_o(frame_clock_sel_o), .bad_config_o(bad_config_o));
	lcd_panel_model panel (.com_en_i(com_en_o), .seg_en_i(seg_drive_en_o),
		.expansion_i(expansion_en_o), .commons_wired_o(wired),
		.segments_lit_o(lit));

	// 250 MHz clock
	always #2 sys_clk_i = ~sys_clk_i;

	task automatic report_and_stop();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// One single-word transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [7:0] d, output logic [31:0] r);
		@(posedge sys_clk_i);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= w;
		haddr_i <= {20'h0, a};
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= {24'h0, d};
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask

	// Outputs trail the register by one edge; wait two to be safe
	task automatic settle();
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		settle();
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, rd);
		`CHK(rd, {24'h0, e});
	endtask

	task automatic stby(input logic v);
		@(posedge sys_clk_i);
		standby_i <= v;
		settle();
	endtask

	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
		settle();
		rd_chk(P, 8'h00);
		rd_chk(C, 8'h80);
		`CHK({com_en_o, com_count_o}, 7'h09);
		`CHK({seg_drive_en_o, expansion_en_o}, 41'h0);
		`CHK(drive_supply_on_o, 1'b0);
		// Power and display control
		wr(C, 8'h00);
		rd_chk(C, 8'h80);
		wr(C, 8'h7f);
		rd_chk(C, 8'hff);
		`CHK({drive_supply_on_o, controller_run_o, show_memory_o,
			frame_clock_sel_o}, 7'h7f);
		stby(1'b1);
		`CHK(drive_supply_on_o, 1'b0);
		stby(1'b0);
		`CHK(drive_supply_on_o, 1'b1);
		wr(C, 8'h5a);
		`CHK({drive_supply_on_o, controller_run_o, show_memory_o,
			frame_clock_sel_o}, 7'h1a);
		rd_chk(C, 8'hda);
		wr(C, 8'h2c);
		`CHK({drive_supply_on_o, controller_run_o, show_memory_o,
			frame_clock_sel_o}, 7'h2c);
		// Every duty with and without paralleling
		for (int i = 0; i < 8; i++) begin
			wr(P, {i[2:0], 5'h0});
			`CHK(com_en_o, en_tab[i]);
			`CHK(com_src_o, src_tab[i]);
			`CHK(com_count_o, 3'(i / 2 + 1));
			`CHK(wired, 3'($countones(en_tab[i])));
		end
		// Every segment group field with expansion off
		for (int i = 0; i < 16; i++) begin
			g = (i == 0) ? 0 : (i == 1) ? 1 : (i >= 8) ? 5 : i / 2 + 1;
			exp_seg = ~({40{1'b1}} >> (8 * g));
			wr(P, 8'(i));
			rd_chk(P, 8'(i));
			`CHK(seg_drive_en_o, exp_seg);
			`CHK(lit, 6'(8 * g));
			`CHK({expansion_en_o, bad_config_o}, 2'b00);
		end
		// Expansion on, legal then prohibited field
		wr(P, 8'h10);
		`CHK({expansion_en_o, bad_config_o}, 2'b10);
		`CHK(seg_drive_en_o, 40'h0);
		wr(P, 8'h13);
		rd_chk(P, 8'h13);
		`CHK({expansion_en_o, bad_config_o}, 2'b11);
		`CHK(seg_drive_en_o, 40'h0);
		rd_chk(S, 8'h06);
		// Unmapped place reads zero and ignores writes
		wr(12'h00c, 8'hff);
		rd_chk(12'h00c, 8'h00);
		`CHK(hresp_o, 1'b0);
		report_and_stop();
	end
endmodule
